// ---- src/upr_phy.sv ----
// Transceiver end: debug, scratch and power-control registers with the
// immediate, escape and extended address decode, receive commands on
// session-valid edges and the shared reset / power-switch pin.
// Assumes the link holds req with stable fields until it sees ack.
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "upr_map.svh"

module upr_phy (
   // Clock and reset.
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // Link side.
   upr_if.phy              bus,
   // Analogue front-end status, asynchronous to hclk.
   input  wire logic [1:0] line_state,
   input  wire logic       bvalid,
   // Request from the power manager to switch the bus supply on.
   input  wire logic       power_on,
   // Shared reset / power-switch pin.
   input  wire logic       shared_pin_in,
   output logic            shared_pin_out,
   output logic            shared_pin_oe,
   // Reset request seen on the shared pin, active low.
   output logic            pin_reset_n
);
   import upr_pkg::*;

   upr_phy_s q;
   upr_phy_s d;

   logic [7:0] eff_addr;
   logic       addr_ok;

   // Applies a write, set or clear at one of a register's three addresses.
   function automatic upr_byte_t apply_op(
      input upr_byte_t  old,
      input upr_byte_t  data,
      input logic [7:0] addr,
      input logic [7:0] base
   );
      upr_byte_t res;
      res = old;
      if (addr == base) begin
         res = data;
      end else if (addr == base + 8'h01) begin
         res = old | data;
      end else if (addr == base + 8'h02) begin
         res = old & ~data;
      end
      return res;
   endfunction

   // True for any address of a three-address register group.
   function automatic logic in_group(
      input logic [7:0] addr,
      input logic [7:0] base
   );
      return (addr >= base) && (addr <= base + 8'h02);
   endfunction

   // True for the maker-specific block at the top of the immediate map.
   function automatic logic in_vendor(
      input logic [7:0] addr
   );
      return (addr >= `UPR_ADDR_VENDOR_LO) && (addr <= `UPR_ADDR_VENDOR_HI);
   endfunction

   always_comb begin
      // Extended accesses reach the same immediate registers; anything
      // above the alias range has no target and reads as zero.
      eff_addr = bus.addr;
      addr_ok  = 1'b1;
      if (bus.ext && (bus.addr > `UPR_ADDR_EXT_ALIAS_TOP)) begin
         addr_ok = 1'b0;
      end
      // The escape address carries no register of its own.
      if (!bus.ext && (bus.addr == `UPR_ADDR_ESCAPE)) begin
         addr_ok = 1'b0;
      end
      // The unimplemented block is refused here rather than left to fall
      // through the decode, so a register added to the map later cannot
      // pick up accesses that must stay without effect.
      if (eff_addr >= `UPR_ADDR_UNIMPL_LO &&
          eff_addr <= `UPR_ADDR_UNIMPL_HI) begin
         addr_ok = 1'b0;
      end
   end

   always_comb begin
      d = q;
      d.rx_valid = 1'b0;

      // Three-stage synchronisers; a new level counts once stages two and
      // three agree, so a single metastable sample is never acted on.
      d.ls_s1 = line_state;
      d.ls_s2 = q.ls_s1;
      d.ls_s3 = q.ls_s2;
      if (q.ls_s2 == q.ls_s3) begin
         d.ls_stable = q.ls_s3;
      end
      d.bv_sync = {q.bv_sync[1:0], bvalid};
      d.rst_sync = {q.rst_sync[1:0], shared_pin_in};
      if (q.rst_sync[1] == q.rst_sync[2]) begin
         d.rst_stable = q.rst_sync[2];
      end

      // Session-valid edges raise an alternate receive command.
      if (q.bv_sync[1] == q.bv_sync[2]) begin
         d.bv_stable = q.bv_sync[2];
         if (q.bv_stable && !q.bv_sync[2] &&
             q.power[`UPR_POWER_BVALID_FALL]) begin
            d.rx_valid = 1'b1;
         end
         if (!q.bv_stable && q.bv_sync[2] &&
             q.power[`UPR_POWER_BVALID_RISE]) begin
            d.rx_valid = 1'b1;
         end
      end
      if (d.rx_valid) begin
         d.rx_ls = q.ls_stable;
      end

      // One acknowledge per request; the access acts on the cycle it is
      // taken, and read data reflect the registers before that access.
      d.ack = bus.req && !q.ack;
      if (d.ack) begin
         d.rdata = 8'h00;
         if (addr_ok) begin
            if (eff_addr == `UPR_ADDR_LINE_STATE_DEBUG) begin
               // Reads the synchronised level, a few cycles behind the pins.
               d.rdata = {6'h00, q.ls_stable};
            end else if (in_group(eff_addr, `UPR_ADDR_SCRATCH_WR)) begin
               d.rdata = q.scratch;
            end else if (in_vendor(eff_addr)) begin
               // Vendor region: only the power-control group is backed.
               if (in_group(eff_addr, `UPR_ADDR_POWER_WR)) begin
                  d.rdata = q.power;
               end
            end
         end
         // Debug is read-only and the unimplemented range is refused by
         // addr_ok, so neither update below changes any state.
         if (bus.we && addr_ok) begin
            if (in_group(eff_addr, `UPR_ADDR_SCRATCH_WR)) begin
               d.scratch = apply_op(q.scratch, bus.wdata, eff_addr,
                                    `UPR_ADDR_SCRATCH_WR);
            end
            if (in_group(eff_addr, `UPR_ADDR_POWER_WR)) begin
               d.power = apply_op(q.power, bus.wdata, eff_addr,
                                  `UPR_ADDR_POWER_WR);
            end
         end
      end

      // Bit 0 hands the shared pin over to the power-switch function;
      // while it does, a low level on the pin is not taken as a reset.
      d.reset_n = q.rst_stable || q.power[`UPR_POWER_PIN_ROLE];
      d.active_low_power_switch_output   = ~power_on;
   end

   // The pin synchroniser resets to the pin's idle high level, so the
   // release of reset never looks like a reset request on the shared pin.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q            <= '0;
         q.scratch    <= `UPR_SCRATCH_RESET;
         q.power      <= `UPR_POWER_RESET;
         q.rst_sync   <= 3'h7;
         q.rst_stable <= 1'b1;
         q.reset_n    <= 1'b1;
         q.active_low_power_switch_output      <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // The scratch byte feeds nothing but the read path.
   assign bus.ack                      = q.ack;
   assign bus.rdata                    = q.rdata;
   assign bus.rx_valid                 = q.rx_valid;
   // Only alternate commands are ever sent, so the flag is the strobe.
   assign bus.alternate_interrupt_flag = q.rx_valid;
   assign bus.rx_line_state            = q.rx_ls;

   // The pin drives only in power-switch role; otherwise it is an input.
   assign shared_pin_oe  = q.power[`UPR_POWER_PIN_ROLE];
   assign shared_pin_out = q.active_low_power_switch_output;
   assign pin_reset_n    = q.reset_n;

endmodule
`default_nettype wire

// ---- src/upr_map.svh ----
// Register addresses, field positions, reset values and bus offsets shared
// by the transceiver end and the link end of the register path.
// Assumes it is included by bare name from files under src/.
`ifndef UPR_MAP_SVH
`define UPR_MAP_SVH

// Immediate register addresses seen over the link.
`define UPR_ADDR_LINE_STATE_DEBUG 8'h15
`define UPR_ADDR_SCRATCH_WR       8'h16
`define UPR_ADDR_SCRATCH_SET      8'h17
`define UPR_ADDR_SCRATCH_CLR      8'h18
`define UPR_ADDR_UNIMPL_LO        8'h19
`define UPR_ADDR_UNIMPL_HI        8'h2E
`define UPR_ADDR_ESCAPE           8'h2F
`define UPR_ADDR_VENDOR_LO        8'h30
`define UPR_ADDR_VENDOR_HI        8'h3F
`define UPR_ADDR_POWER_WR         8'h3D
`define UPR_ADDR_POWER_SET        8'h3E
`define UPR_ADDR_POWER_CLR        8'h3F
`define UPR_ADDR_EXT_ALIAS_TOP    8'h3F

// Field layout and reset values.
`define UPR_LINE_STATE_MASK       8'h03
`define UPR_SCRATCH_RESET         8'h00
`define UPR_POWER_RESET           8'h00
`define UPR_POWER_RSVD_MASK       8'hF2
`define UPR_POWER_BVALID_FALL     3
`define UPR_POWER_BVALID_RISE     2
`define UPR_POWER_PIN_ROLE        0

// Link-end register offsets on the AHB-Lite bus (byte addresses).
`define UPR_AHB_CTRL              8'h00
`define UPR_AHB_STATUS            8'h04
`define UPR_AHB_IRQ_STATUS        8'h08
`define UPR_AHB_IRQ_MASK          8'h0C

// Link-end field positions.
`define UPR_CTRL_START            0
`define UPR_CTRL_WRITE            1
`define UPR_CTRL_EXT              2
`define UPR_IRQ_DONE              0
`define UPR_IRQ_ALT               1

`endif

// ---- src/upr_pkg.sv ----
// Types shared by both ends of the upper register path.
// Assumes the constants of upr_map.svh are used alongside.
package upr_pkg;

   typedef logic [7:0] upr_byte_t;

   // Link command sequencer, Gray coded.
   typedef enum logic [1:0] {
      UPR_LINK_IDLE = 2'b00,
      UPR_LINK_WAIT = 2'b01
   } upr_link_e;

   typedef struct packed {
      upr_byte_t  scratch;
      upr_byte_t  power;
      logic       ack;
      upr_byte_t  rdata;
      logic       rx_valid;
      logic [1:0] rx_ls;
      logic [2:0] bv_sync;
      logic       bv_stable;
      logic [2:0] rst_sync;
      logic       rst_stable;
      logic [1:0] ls_s1;
      logic [1:0] ls_s2;
      logic [1:0] ls_s3;
      logic [1:0] ls_stable;
      logic       reset_n;
      logic       active_low_power_switch_output;
   } upr_phy_s;

   typedef struct packed {
      upr_link_e   fsm;
      logic        req;
      logic        we;
      logic        ext;
      upr_byte_t   addr;
      upr_byte_t   wdata;
      upr_byte_t   rdata;
      logic [1:0]  ls;
      logic [1:0]  irq_sts;
      logic [1:0]  irq_mask;
      logic        dph_wr;
      logic [7:0]  dph_addr;
      logic [31:0] hrdata;
   } upr_link_s;

endpackage

// ---- src/upr_if.sv ----
// Register access and receive-command path between the link and the
// transceiver. Both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface upr_if;
   logic       req;
   logic       we;
   logic       ext;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic       ack;
   logic [7:0] rdata;
   logic       rx_valid;
   logic       alternate_interrupt_flag;
   logic [1:0] rx_line_state;

   modport link (
      output req, we, ext, addr, wdata,
      input  ack, rdata, rx_valid, alternate_interrupt_flag, rx_line_state
   );
   modport phy (
      input  req, we, ext, addr, wdata,
      output ack, rdata, rx_valid, alternate_interrupt_flag, rx_line_state
   );
endinterface
`default_nettype wire

// ---- src/upr_link.sv ----
// Link end: software issues single register accesses to the transceiver
// through AHB-Lite registers and is told of completion and of alternate
// receive commands by a masked interrupt.
// Assumes a single AHB-Lite master and the transceiver on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "upr_map.svh"

module upr_link (
   // Clock and reset.
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave.
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Interrupt, high while an unmasked status bit is set.
   output logic             irq,
   // Transceiver side.
   upr_if.link              bus
);
   import upr_pkg::*;

   upr_link_s  q;
   upr_link_s  d;
   logic [1:0] w1c;
   logic [1:0] set_ev;

   function automatic logic [31:0] read_word(
      input upr_link_s  s,
      input logic [7:0] a
   );
      logic [31:0] r;
      r = 32'h0000_0000;
      case (a)
         `UPR_AHB_CTRL: begin
            r = {8'h00, s.wdata, s.addr, 5'h00, s.ext, s.we, 1'b0};
         end
         `UPR_AHB_STATUS: begin
            r = {14'h0000, s.ls, s.rdata, 7'h00, s.fsm != UPR_LINK_IDLE};
         end
         `UPR_AHB_IRQ_STATUS: r = {30'h0000_0000, s.irq_sts};
         `UPR_AHB_IRQ_MASK:   r = {30'h0000_0000, s.irq_mask};
         default:             r = 32'h0000_0000;
      endcase
      return r;
   endfunction

   always_comb begin
      d      = q;
      w1c    = 2'b00;
      set_ev = 2'b00;

      // Data phase of a write.
      if (q.dph_wr) begin
         case (q.dph_addr)
            `UPR_AHB_CTRL: begin
               // A start while busy is ignored.
               if (hwdata[`UPR_CTRL_START] && q.fsm == UPR_LINK_IDLE) begin
                  d.we    = hwdata[`UPR_CTRL_WRITE];
                  d.ext   = hwdata[`UPR_CTRL_EXT];
                  d.addr  = hwdata[15:8];
                  d.wdata = hwdata[23:16];
                  // Power-control writes never carry reserved ones.
                  if (hwdata[15:8] >= `UPR_ADDR_POWER_WR &&
                      hwdata[15:8] <= `UPR_ADDR_POWER_CLR) begin
                     d.wdata = hwdata[23:16] & ~`UPR_POWER_RSVD_MASK;
                  end
                  d.rdata = 8'h00;
                  // Extended addresses past the alias range are never sent.
                  if (hwdata[`UPR_CTRL_EXT] &&
                      hwdata[15:8] > `UPR_ADDR_EXT_ALIAS_TOP) begin
                     set_ev[`UPR_IRQ_DONE] = 1'b1;
                  end else begin
                     d.req = 1'b1;
                     d.fsm = UPR_LINK_WAIT;
                  end
               end
            end
            `UPR_AHB_IRQ_STATUS: w1c = hwdata[1:0];
            `UPR_AHB_IRQ_MASK:   d.irq_mask = hwdata[1:0];
            default: begin
            end
         endcase
      end

      case (q.fsm)
         UPR_LINK_IDLE: begin
         end
         UPR_LINK_WAIT: begin
            if (bus.ack) begin
               d.req   = 1'b0;
               d.rdata = bus.rdata;
               d.fsm   = UPR_LINK_IDLE;
               set_ev[`UPR_IRQ_DONE] = 1'b1;
            end
         end
         default: begin
            d.req = 1'b0;
            d.fsm = UPR_LINK_IDLE;
         end
      endcase

      // Alternate commands only flag software; session tracking should
      // use the comparator events instead.
      if (bus.rx_valid && bus.alternate_interrupt_flag) begin
         set_ev[`UPR_IRQ_ALT] = 1'b1;
         d.ls = bus.rx_line_state;
      end
      // An event in the clearing cycle survives the clear.
      d.irq_sts = (q.irq_sts & ~w1c) | set_ev;

      // Address phase; reads see this cycle's write already applied.
      d.dph_wr = 1'b0;
      if (hsel && htrans[1] && hready) begin
         d.dph_wr   = hwrite;
         d.dph_addr = haddr[7:0];
         if (!hwrite) begin
            d.hrdata = read_word(d, haddr[7:0]);
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q     <= '0;
         q.fsm <= UPR_LINK_IDLE;
      end else begin
         q <= d;
      end
   end

   // Every access completes without wait states; software sets the pin
   // role bit itself when a ganged power switch is fitted.
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = q.hrdata;
   assign irq       = |(q.irq_sts & q.irq_mask);
   assign bus.req   = q.req;
   assign bus.we    = q.we;
   assign bus.ext   = q.ext;
   assign bus.addr  = q.addr;
   assign bus.wdata = q.wdata;

endmodule
`default_nettype wire

// ---- sim/upr_sva.sv ----
// Interface checker for the link to transceiver register path.
// Assumes it sits beside the interface that joins both ends, one clock.
`timescale 1ns/1ps
`default_nettype none
module upr_sva (
   // Clock and reset.
   input wire logic       hclk,
   input wire logic       hresetn,
   // Link to transceiver.
   input wire logic       req,
   input wire logic       we,
   input wire logic       ext,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   // Transceiver to link.
   input wire logic       ack,
   input wire logic [7:0] rdata,
   input wire logic       rx_valid,
   input wire logic       alternate_interrupt_flag,
   input wire logic [1:0] rx_line_state
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence take_s;
      $rose(req);
   endsequence
   sequence rd_done_s;
      ack && !we;
   endsequence
   sequence pulse_s;
      ack ##1 !ack;
   endsequence

   ack_latency_a: assert property (take_s |=> pulse_s)
      else $error("ack not one cycle after request");
   req_hold_a: assert property (req && !ack |=>
      req && $stable(addr) && $stable(wdata) && $stable(we))
      else $error("request changed before ack");
   req_drop_a: assert property (ack |=> !req)
      else $error("request held after ack");
   debug_ro_a: assert property (
      (rd_done_s and (!ext && addr == 8'h15)) |-> rdata[7:2] == 6'h00)
      else $error("debug upper bits not zero");
   unimpl_zero_a: assert property (
      (rd_done_s and (addr inside {[8'h19:8'h2E]})) |-> rdata == 8'h00)
      else $error("unimplemented address read not zero");
   escape_zero_a: assert property (
      (rd_done_s and (!ext && addr == 8'h2F)) |-> rdata == 8'h00)
      else $error("escape read data");
   vendor_gap_a: assert property (
      (rd_done_s and (addr inside {[8'h30:8'h3C]})) |-> rdata == 8'h00)
      else $error("empty vendor address read not zero");
   rsvd_write_a: assert property (req && we &&
      addr inside {[8'h3D:8'h3F]} |-> (wdata & 8'hF2) == 8'h00)
      else $error("reserved power bit written as one");
   ext_range_a: assert property (req && ext |-> addr <= 8'h3F)
      else $error("extended address above alias range");
   alt_flag_a: assert property (rx_valid |->
      alternate_interrupt_flag ##1 !rx_valid)
      else $error("receive command without alternate flag");
   flag_only_a: assert property (alternate_interrupt_flag |-> rx_valid)
      else $error("alternate flag outside receive command");
endmodule
`default_nettype wire

// ---- sim/test_ulpi_phy_upper_register_map.sv ----
// Testbench: both ends joined, software side driven over AHB-Lite.
// Assumes upr_map.svh is on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "upr_map.svh"
module test_ulpi_phy_upper_register_map;
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans, line_state;
   logic [2:0]  hsize;
   logic        irq, bvalid, power_on, shared_pin_in;
   logic        shared_pin_out, shared_pin_oe, pin_reset_n;
   int          err_count, samples_checked;

   upr_if upr_if_inst ();
   assign hready = hreadyout;
   upr_link upr_link_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .irq(irq), .bus(upr_if_inst.link));
   upr_phy upr_phy_inst (.hclk(hclk), .hresetn(hresetn),
      .bus(upr_if_inst.phy), .line_state(line_state), .bvalid(bvalid),
      .power_on(power_on), .shared_pin_in(shared_pin_in),
      .shared_pin_out(shared_pin_out), .shared_pin_oe(shared_pin_oe),
      .pin_reset_n(pin_reset_n));
   upr_sva upr_sva_inst (.hclk(hclk), .hresetn(hresetn),
      .req(upr_if_inst.req), .we(upr_if_inst.we), .ext(upr_if_inst.ext),
      .addr(upr_if_inst.addr), .wdata(upr_if_inst.wdata),
      .ack(upr_if_inst.ack), .rdata(upr_if_inst.rdata),
      .rx_valid(upr_if_inst.rx_valid),
      .alternate_interrupt_flag(upr_if_inst.alternate_interrupt_flag),
      .rx_line_state(upr_if_inst.rx_line_state));

   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Every wait is bounded so a stuck handshake ends the run.
   task automatic wait_rdy;
      int n;
      n = 0;
      @(posedge hclk);
      while (hready !== 1'b1 && n < 64) begin
         @(posedge hclk);
         n++;
      end
      if (hready !== 1'b1) begin
         err_count++;
         tally_and_finish();
      end
   endtask

   task automatic ahb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      hsel   <= 1'b1;
      haddr  <= {24'h00_0000, a};
      hwrite <= w;
      htrans <= 2'b10;
      wait_rdy();
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy();
      r = hrdata;
   endtask

   task automatic phy(input logic w, input logic e, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] rd);
      logic [31:0] s;
      int          n;
      n = 0;
      ahb(1'b1, `UPR_AHB_CTRL, {8'h00, d, a, 5'h00, e, w, 1'b1}, s);
      s = 32'h0000_0001;
      while (s[0] !== 1'b0 && n < 20) begin
         ahb(1'b0, `UPR_AHB_STATUS, 32'h0000_0000, s);
         n++;
      end
      if (s[0] !== 1'b0) begin
         err_count++;
         tally_and_finish();
      end
      rd = s[15:8];
   endtask

   task automatic prd(input logic e, input logic [7:0] a,
                      input logic [7:0] exp);
      logic [7:0] r;
      phy(1'b0, e, a, 8'h00, r);
      chk({24'h00_0000, r}, {24'h00_0000, exp});
   endtask

   task automatic pwr(input logic e, input logic [7:0] a,
                      input logic [7:0] d);
      logic [7:0] r;
      phy(1'b1, e, a, d, r);
   endtask

   task automatic t_reset;
      logic [31:0] r;
      prd(1'b0, 8'h16, 8'h00);
      prd(1'b0, 8'h3D, 8'h00);
      prd(1'b0, 8'h15, 8'h00);
      chk({31'h0000_0000, shared_pin_oe}, 32'h0000_0000);
      chk({31'h0000_0000, hresp}, 32'h0000_0000);
      ahb(1'b0, 8'h10, 32'h0000_0000, r);
      chk(r, 32'h0000_0000);
      $display("reset test done");
   endtask

   task automatic t_scratch;
      pwr(1'b0, 8'h16, 8'hA5);
      prd(1'b0, 8'h17, 8'hA5);
      prd(1'b0, 8'h18, 8'hA5);
      pwr(1'b0, 8'h17, 8'h0A);
      prd(1'b0, 8'h16, 8'hAF);
      pwr(1'b0, 8'h18, 8'h05);
      prd(1'b0, 8'h16, 8'hAA);
      prd(1'b0, 8'h3D, 8'h00);
      $display("scratch test done");
   endtask

   task automatic t_debug;
      line_state <= 2'b10;
      repeat (8) @(posedge hclk);
      prd(1'b0, 8'h15, 8'h02);
      pwr(1'b0, 8'h15, 8'hFF);
      prd(1'b0, 8'h15, 8'h02);
      line_state <= 2'b01;
      repeat (8) @(posedge hclk);
      prd(1'b0, 8'h15, 8'h01);
      $display("debug test done");
   endtask

   task automatic t_unmapped;
      logic [7:0] al [5] = '{8'h19, 8'h2E, 8'h2F, 8'h30, 8'h3C};
      foreach (al[i]) begin
         pwr(1'b0, al[i], 8'hFF);
         prd(1'b0, al[i], 8'h00);
      end
      prd(1'b0, 8'h16, 8'hAA);
      prd(1'b0, 8'h3D, 8'h00);
      $display("unmapped test done");
   endtask

   task automatic t_ext;
      pwr(1'b1, 8'h16, 8'h3C);
      prd(1'b0, 8'h16, 8'h3C);
      pwr(1'b1, 8'h17, 8'h03);
      prd(1'b1, 8'h18, 8'h3F);
      pwr(1'b1, 8'h56, 8'hFF);
      prd(1'b1, 8'h56, 8'h00);
      prd(1'b0, 8'h16, 8'h3F);
      pwr(1'b0, 8'h3D, 8'h08);
      prd(1'b1, 8'h3D, 8'h08);
      pwr(1'b1, 8'h3F, 8'h08);
      prd(1'b0, 8'h3E, 8'h00);
      $display("extended test done");
   endtask

   task automatic t_pin;
      power_on      <= 1'b1;
      shared_pin_in <= 1'b0;
      pwr(1'b0, 8'h3D, 8'hFF);
      prd(1'b0, 8'h3F, 8'h0D);
      pwr(1'b0, 8'h3D, 8'h01);
      repeat (6) @(posedge hclk);
      chk({29'h0000_0000, shared_pin_oe, shared_pin_out, pin_reset_n},
          32'h0000_0005);
      power_on <= 1'b0;
      repeat (4) @(posedge hclk);
      chk({31'h0000_0000, shared_pin_out}, 32'h0000_0001);
      pwr(1'b0, 8'h3F, 8'h01);
      repeat (8) @(posedge hclk);
      chk({30'h0000_0000, shared_pin_oe, pin_reset_n},
          32'h0000_0000);
      shared_pin_in <= 1'b1;
      repeat (8) @(posedge hclk);
      chk({31'h0000_0000, pin_reset_n}, 32'h0000_0001);
      $display("pin test done");
   endtask

   // The status bit records every enabled edge; the pin shows it only
   // while the alternate bit is unmasked.
   task automatic bv_case(input logic [7:0] en, input logic v,
                          input logic exp, input logic msk);
      logic [31:0] r;
      pwr(1'b0, 8'h3D, en);
      ahb(1'b1, `UPR_AHB_IRQ_STATUS, 32'h0000_0003, r);
      bvalid <= v;
      repeat (12) @(posedge hclk);
      chk({31'h0000_0000, irq}, {31'h0000_0000, exp & msk});
      ahb(1'b0, `UPR_AHB_IRQ_STATUS, 32'h0000_0000, r);
      chk({31'h0000_0000, r[1]}, {31'h0000_0000, exp});
   endtask

   task automatic t_alt;
      logic [9:0]  tbl [6] = '{{8'h04, 2'b11}, {8'h04, 2'b00},
         {8'h08, 2'b10}, {8'h08, 2'b01}, {8'h0C, 2'b11}, {8'h00, 2'b00}};
      logic [31:0] r;
      ahb(1'b1, `UPR_AHB_IRQ_MASK, 32'h0000_0002, r);
      foreach (tbl[i]) begin
         bv_case(tbl[i][9:2], tbl[i][1], tbl[i][0], 1'b1);
      end
      ahb(1'b1, `UPR_AHB_IRQ_MASK, 32'h0000_0000, r);
      bv_case(8'h04, 1'b1, 1'b1, 1'b0);
      ahb(1'b0, `UPR_AHB_STATUS, 32'h0000_0000, r);
      chk({30'h0000_0000, r[17:16]}, 32'h0000_0001);
      ahb(1'b0, `UPR_AHB_IRQ_STATUS, 32'h0000_0000, r);
      chk(r, 32'h0000_0002);
      ahb(1'b1, `UPR_AHB_IRQ_MASK, 32'h0000_0002, r);
      // The pin follows the flops one edge after the data phase.
      @(posedge hclk);
      chk({31'h0000_0000, irq}, 32'h0000_0001);
      ahb(1'b1, `UPR_AHB_IRQ_STATUS, 32'h0000_0003, r);
      @(posedge hclk);
      chk({31'h0000_0000, irq}, 32'h0000_0000);
      $display("alternate command test done");
   endtask

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0000_0000;
      line_state = 2'b00;
      bvalid = 1'b0;
      power_on = 1'b0;
      shared_pin_in = 1'b1;
      err_count = 0;
      samples_checked = 0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      t_scratch();
      t_debug();
      t_unmapped();
      t_ext();
      t_pin();
      t_alt();
      tally_and_finish();
   end
endmodule
`default_nettype wire
